// ### design/lrc_pkg.sv
package lrc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int          LRC_ADDR_W        = 12;
    localparam int          LRC_DATA_W        = 32;
    localparam int          LRC_REG_W         = 8;

    // Register indices; byte address is four times the index
    localparam logic [11:0] LRC_CTRL_IDX      = 12'h09f;
    localparam logic [11:0] LRC_STAT_IDX      = 12'h0a0;
    localparam logic [11:0] LRC_CTRL_ADDR     = {LRC_CTRL_IDX[9:0], 2'b00};
    localparam logic [11:0] LRC_STAT_ADDR     = {LRC_STAT_IDX[9:0], 2'b00};

    ////////////////////////////////////////////////////////////////////////
    // Control register layout
    localparam int          LRC_PWR_BIT       = 7;
    localparam int          LRC_OE_BIT        = 6;
    localparam int          LRC_RANGE_BIT     = 5;
    localparam int          LRC_UNUSED_BIT    = 4;
    localparam int          LRC_TAP_MSB       = 3;
    localparam int          LRC_TAP_LSB       = 0;
    localparam int          LRC_TAP_W         = 4;
    localparam logic [7:0]  LRC_CTRL_RESET    = 8'h00;
    localparam logic [7:0]  LRC_CTRL_MASK     = 8'hef;

    // Status register layout
    localparam int          LRC_ST_PIN_BIT    = 0;
    localparam int          LRC_ST_CMP_BIT    = 1;
    localparam int          LRC_ST_LADDER_BIT = 2;
    localparam int          LRC_ST_SLEEP_BIT  = 3;

    ////////////////////////////////////////////////////////////////////////
    // Ladder geometry: taps per range and the divisors of each range
    localparam int          LRC_NUM_TAPS      = 16;
    localparam int          LRC_LOW_DIV       = 24;
    localparam int          LRC_HIGH_DIV      = 32;
    localparam int          LRC_HIGH_OFS_DIV  = 4;

    // Comparator mode code that routes the reference to both comparators
    localparam int          LRC_CMP_MODE_W    = 3;
    localparam logic [2:0]  LRC_CMP_INTREF    = 3'h2;

endpackage : lrc_pkg

// ### design/lrc_tap_decoder.sv
module lrc_tap_decoder
    import lrc_pkg::*;
#(
    parameter int NUM_TAPS = LRC_NUM_TAPS,
    parameter int TAP_W    = LRC_TAP_W
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                power_en,
    input  wire logic                range_sel,
    input  wire logic [TAP_W-1:0]    tap_value,
    output logic      [NUM_TAPS-1:0] tap_select,
    output logic                     range_low,
    output logic                     range_high
);

    ////////////////////////////////////////////////////////////////////////
    // One flop per tap, so switch glitches never reach the ladder
    for (genvar i = 0; i < NUM_TAPS; i++) begin : g_tap
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                tap_select[i] <= 1'b0;
            end else begin
                tap_select[i] <= power_en && (tap_value == TAP_W'(i));
            end
        end
    end

    // Range segment controls, both idle while the ladder is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            range_low  <= 1'b0;
            range_high <= 1'b0;
        end else begin
            range_low  <= power_en && range_sel;
            range_high <= power_en && !range_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_TAP_ONEHOT: assert property (@(posedge pclk) disable iff (!presetn)
        power_en |=> $onehot(tap_select) && tap_select[$past(tap_value)])
        else $error("tap select not one-hot on the written tap");

    AST_OFF_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        !power_en |=> (tap_select == '0) && !range_low && !range_high)
        else $error("ladder controls active while powered down");

endmodule : lrc_tap_decoder

// ### design/lrc_ref_router.sv
module lrc_ref_router
    import lrc_pkg::*;
(
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      pin_oe,
    input  wire logic                      pin_direction,
    input  wire logic [LRC_CMP_MODE_W-1:0] comparator_mode,
    output logic                           pin_connect,
    output logic                           comp_ref_en
);

    ////////////////////////////////////////////////////////////////////////
    // Pin switch needs both the port direction and the output enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_connect <= 1'b0;
        end else begin
            pin_connect <= pin_oe && pin_direction;
        end
    end

    // Comparator tap-off follows the comparator mode alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comp_ref_en <= 1'b0;
        end else begin
            comp_ref_en <= (comparator_mode == LRC_CMP_INTREF);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_PIN_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 pin_connect == ($past(pin_oe) && $past(pin_direction)))
        else $error("pin switch does not follow direction and enable");

    AST_CMP_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
        presetn |=> comp_ref_en == $past(comparator_mode == LRC_CMP_INTREF))
        else $error("reference routing does not follow the comparator mode");

endmodule : lrc_ref_router

// ### design/lrc_top.sv
// Operation
// - One 8-bit control word holds power enable, pin enable, range and a 4-bit tap; bit 4 reads 0.
// - Each range offers sixteen levels picked by the tap field.
// - Range bit 1 sets the ladder to tap/24 of supply, 0 to a quarter plus tap/32.
// - Every reset clears the power enable so the ladder is off.
// - Every reset also clears pin enable, range and tap, so the word reads all zeros.
// - The pin is switched to the reference only while its direction bit and pin enable are set.
// - Waking from sleep leaves the control word untouched.
// - Comparator mode settings never change enable, range, tap or pin state.
// - The reference feeds both comparator positive inputs in the internal reference mode.
//
// Implementation choice: the APB register port.
module lrc_top
    import lrc_pkg::*;
#(
    parameter int ADDR_W   = LRC_ADDR_W,
    parameter int NUM_TAPS = LRC_NUM_TAPS
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // APB slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [ADDR_W-1:0]         paddr,
    input  wire logic [LRC_DATA_W-1:0]     pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [LRC_DATA_W-1:0]     prdata,
    output logic                           pready,
    output logic                           pslverr,
    // Neighbouring blocks
    input  wire logic                      reference_pin_direction,
    input  wire logic [LRC_CMP_MODE_W-1:0] comparator_mode,
    input  wire logic                      sleep_active,
    // Analog ladder and switch controls
    output logic                           ref_ladder_power,
    output logic      [NUM_TAPS-1:0]       ref_tap_select,
    output logic                           ref_range_low,
    output logic                           ref_range_high,
    output logic                           reference_port_pin,
    output logic                           comp_int_ref_en
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    logic                  ctrl_hit;
    logic                  stat_hit;
    logic                  setup_ph;
    logic                  access_ph;
    logic                  ctrl_wr;
    logic                  bad_access;
    logic [LRC_REG_W-1:0]  read_mux;

    // Word aligned compare; low address bits are ignored
    assign ctrl_hit  = (paddr[ADDR_W-1:2] == LRC_CTRL_ADDR[ADDR_W-1:2]);
    assign stat_hit  = (paddr[ADDR_W-1:2] == LRC_STAT_ADDR[ADDR_W-1:2]);
    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable;

    // Status is read-only, so a write to it is an error
    assign bad_access = !(ctrl_hit || stat_hit) || (pwrite && stat_hit);

    // Only lane 0 carries the 8-bit word; other lanes are ignored
    assign ctrl_wr = access_ph && pwrite && ctrl_hit && pstrb[0];

    ////////////////////////////////////////////////////////////////////////
    // Control register

    logic [LRC_REG_W-1:0]  ctrl_q;
    logic [LRC_REG_W-1:0]  ctrl_d;

    // Bit 4 is never stored, so it cannot read back as one
    assign ctrl_d = pwdata[LRC_REG_W-1:0] & LRC_CTRL_MASK;

    // No sleep or comparator term here: only reset or a bus write changes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= LRC_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_q <= ctrl_d;
        end
    end

    logic                  pwr_en;
    logic                  pin_oe;
    logic                  range_sel;
    logic [LRC_TAP_W-1:0]  tap_value;

    assign pwr_en    = ctrl_q[LRC_PWR_BIT];
    assign pin_oe    = ctrl_q[LRC_OE_BIT];
    assign range_sel = ctrl_q[LRC_RANGE_BIT];
    assign tap_value = ctrl_q[LRC_TAP_MSB:LRC_TAP_LSB];

    ////////////////////////////////////////////////////////////////////////
    // Ladder power, registered so it lines up with the tap selects

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_ladder_power <= 1'b0;
        end else begin
            ref_ladder_power <= pwr_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tap and range decode

    lrc_tap_decoder #(
        .NUM_TAPS   (NUM_TAPS),
        .TAP_W      (LRC_TAP_W)
    ) u_tap_decoder (
        .pclk       (pclk),
        .presetn    (presetn),
        .power_en   (pwr_en),
        .range_sel  (range_sel),
        .tap_value  (tap_value),
        .tap_select (ref_tap_select),
        .range_low  (ref_range_low),
        .range_high (ref_range_high)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin and comparator routing

    lrc_ref_router u_ref_router (
        .pclk            (pclk),
        .presetn         (presetn),
        .pin_oe          (pin_oe),
        .pin_direction   (reference_pin_direction),
        .comparator_mode (comparator_mode),
        .pin_connect     (reference_port_pin),
        .comp_ref_en     (comp_int_ref_en)
    );

    ////////////////////////////////////////////////////////////////////////
    // Status word shows what the analog side is actually being told

    logic [LRC_REG_W-1:0]  stat_word;

    always_comb begin
        stat_word                    = '0;
        stat_word[LRC_ST_PIN_BIT]    = reference_port_pin;
        stat_word[LRC_ST_CMP_BIT]    = comp_int_ref_en;
        stat_word[LRC_ST_LADDER_BIT] = ref_ladder_power;
        stat_word[LRC_ST_SLEEP_BIT]  = sleep_active;
    end

    // Read data select; unmapped reads return zero
    always_comb begin
        read_mux = '0;
        if (ctrl_hit) begin
            read_mux = ctrl_q;
        end else if (stat_hit) begin
            read_mux = stat_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer: data captured in setup, presented in the access phase

    logic [LRC_REG_W-1:0]  prdata_q;
    logic                  err_q;

    // Capturing in setup keeps prdata a flop output with no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (setup_ph) begin
            prdata_q <= pwrite ? '0 : read_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_q <= 1'b0;
        end else if (setup_ph) begin
            err_q <= bad_access;
        end
    end

    // Upper lanes read as zero
    assign prdata  = {{(LRC_DATA_W-LRC_REG_W){1'b0}}, prdata_q};
    assign pready  = access_ph;
    assign pslverr = access_ph && err_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    // Bit 4 and the upper lanes always read as zero
    AST_BIT4_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && !pwrite && ctrl_hit)
            |=> !prdata[LRC_UNUSED_BIT] && prdata[31:8] == '0)
        else $error("unimplemented control bit read as one");

    // A strobed write lands masked on the access edge
    AST_WRITE_STORES: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_wr |=> ctrl_q == ($past(pwdata[7:0]) & LRC_CTRL_MASK))
        else $error("control write not stored as masked");

    // Range bit one picks the tap/24 segment
    AST_RANGE_LOW: assert property (@(posedge pclk) disable iff (!presetn)
        (pwr_en && range_sel) |=> ref_range_low && !ref_range_high)
        else $error("low range not selected for range bit one");

    // Range bit zero picks the quarter-offset segment
    AST_RANGE_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
        (pwr_en && !range_sel) |=> ref_range_high && !ref_range_low)
        else $error("high range not selected for range bit zero");

    // Ladder stays off on the first edge out of reset
    AST_RESET_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(presetn) |-> !ctrl_q[LRC_PWR_BIT] && !ref_ladder_power)
        else $error("power enable set right after reset");

    // Whole word and read path start at zero
    AST_RESET_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(presetn) |-> ctrl_q == LRC_CTRL_RESET && prdata_q == '0)
        else $error("control word not zero after reset");

    // Sleep alone never touches the stored word
    AST_SLEEP_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (sleep_active || $fell(sleep_active)) && !ctrl_wr |=> $stable(ctrl_q))
        else $error("control word changed across sleep");

    // Mode changes are invisible to the ladder side
    AST_CMP_INDEP: assert property (@(posedge pclk) disable iff (!presetn)
        ($changed(comparator_mode) && !ctrl_wr && !$past(ctrl_wr))
            |=> $stable(ref_tap_select) && $stable(ref_range_low)
                && $stable(ref_ladder_power) && $stable(ctrl_q))
        else $error("comparator mode disturbed reference settings");

    // Ladder power trails the written enable by one edge
    AST_POWER_FOLLOW: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_wr ##1 1'b1 |=> ref_ladder_power == $past(ctrl_d[LRC_PWR_BIT], 2))
        else $error("ladder power does not follow power enable");

    // Bad address or status write answers with an error
    AST_APB_ERR: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && bad_access) ##1 access_ph |-> pslverr && pready)
        else $error("bad access not answered with an error");

    // Good accesses never raise an error
    AST_APB_OK: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && !bad_access) ##1 access_ph |-> !pslverr && pready)
        else $error("good access answered with an error");

    ////////////////////////////////////////////////////////////////////////
    // Read path checks

    // Control read returns the word stored at the setup edge
    AST_READ_CTRL: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && !pwrite && ctrl_hit) |=> prdata[LRC_REG_W-1:0] == $past(ctrl_q))
        else $error("control read does not return the stored word");

    // Status bits mirror the controls sent to the analog side
    AST_READ_STAT: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && !pwrite && stat_hit)
            |=> prdata[LRC_ST_PIN_BIT] == $past(reference_port_pin)
                && prdata[LRC_ST_CMP_BIT] == $past(comp_int_ref_en)
                && prdata[LRC_ST_LADDER_BIT] == $past(ref_ladder_power)
                && prdata[LRC_ST_SLEEP_BIT] == $past(sleep_active)
                && prdata[LRC_DATA_W-1:LRC_REG_W] == '0)
        else $error("status read does not mirror the outputs");

    // Unmapped reads return zero on every lane
    AST_READ_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && !ctrl_hit && !stat_hit) |=> prdata == '0)
        else $error("unmapped read returned data");

    ////////////////////////////////////////////////////////////////////////
    // Ladder and switch checks

    // Mode changes leave the pin switch alone while its own inputs hold
    AST_PIN_INDEP: assert property (@(posedge pclk) disable iff (!presetn)
        ($changed(comparator_mode) && $stable(reference_pin_direction) && !$past(ctrl_wr))
            |=> $stable(reference_port_pin))
        else $error("comparator mode moved the pin switch");

    // Every ladder and switch output is off on the first edge out of reset
    AST_RESET_OUTPUTS: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(presetn) |-> ref_tap_select == '0 && !ref_range_low && !ref_range_high
            && !reference_port_pin && !comp_int_ref_en)
        else $error("outputs active right after reset");

    // The powered tap is the one the register held an edge earlier
    AST_TAP_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
        ref_ladder_power |-> ref_tap_select[$past(tap_value)])
        else $error("powered tap does not match the tap field");

    // Ladder power and the tap selects switch on the same edge
    AST_POWER_ON_ALIGN: assert property (@(posedge pclk) disable iff (!presetn)
        ref_ladder_power |-> $onehot(ref_tap_select) && (ref_range_low != ref_range_high))
        else $error("powered ladder without exactly one tap and one range");

    // With the ladder unpowered no tap or segment switch is closed
    AST_POWER_OFF_ALIGN: assert property (@(posedge pclk) disable iff (!presetn)
        !ref_ladder_power |-> ref_tap_select == '0 && !ref_range_low && !ref_range_high)
        else $error("ladder switches closed while unpowered");

    // Both segments at once would short the ladder ends together
    AST_ONE_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
        !(ref_range_low && ref_range_high))
        else $error("both ladder segments selected");

endmodule : lrc_top

// ### dv/test_ladder_reference_control.sv
module test_ladder_reference_control
    import lrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        dir;
    logic [2:0]  cmode;
    logic        sleep;
    logic        power;
    logic [15:0] taps;
    logic        rlow;
    logic        rhigh;
    logic        pin;
    logic        cref;
    int          n_mismatch;
    int          checks_done;

    lrc_top DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reference_pin_direction(dir), .comparator_mode(cmode),
        .sleep_active(sleep), .ref_ladder_power(power), .ref_tap_select(taps),
        .ref_range_low(rlow), .ref_range_high(rhigh), .reference_port_pin(pin),
        .comp_int_ref_en(cref)
    );

    ////////////////////////////////////////////////////////////////////////
    // Free-running 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    // One APB transfer; waits on pready with a bound, never a fixed count
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd,
                       input logic [3:0] st, output logic [31:0] rd, output logic err);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        pstrb   <= st;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            n_mismatch++;
            $display("CHECK FAILED pready expected 1 seen 0");
            close_out();
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st,
                      output logic err);
        logic [31:0] x;
        apb(a, 1'b1, d, st, x, err);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic err);
        apb(a, 1'b0, 32'h0, 4'h0, d, err);
    endtask : rd

    // Registered outputs land one edge after their cause
    task automatic settle();
        repeat (2) @(negedge pclk);
    endtask : settle

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [31:0] d;
        logic        e;
        logic [7:0]  v;
        n_mismatch = 0;
        checks_done = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        dir = 1'b0;
        cmode = 3'h0;
        sleep = 1'b0;
        repeat (8) @(posedge pclk);
        check("outputs in reset", {power, taps, rlow, rhigh, pin, cref}, 32'h0);
        presetn <= 1'b1;
        rd(LRC_CTRL_ADDR, d, e);
        check("control after reset", d, 32'h0);
        $display("test reset done");

        for (int r = 0; r < 2; r++) begin
            for (int t = 0; t < 16; t++) begin
                v = {1'b1, 1'b0, r[0], 1'b0, t[3:0]};
                wr(LRC_CTRL_ADDR, {24'h0, v}, 4'h1, e);
                settle();
                check("tap_select", taps, 32'h1 << t);
                check("range", {rlow, rhigh}, (r == 1) ? 32'h2 : 32'h1);
                check("ladder power", power, 32'h1);
            end
        end
        wr(LRC_CTRL_ADDR, 32'h2f, 4'h1, e);
        settle();
        check("ladder idle", {power, taps, rlow, rhigh}, 32'h0);
        $display("test ladder done");

        wr(LRC_CTRL_ADDR, 32'hffff_ffff, 4'hf, e);
        rd(LRC_CTRL_ADDR, d, e);
        check("control fields", d, 32'hef);
        check("control read error", e, 32'h0);
        wr(LRC_CTRL_ADDR, 32'h00, 4'h0, e);
        rd(LRC_CTRL_ADDR, d, e);
        check("strobe off write", d, 32'hef);
        rd(12'h400, d, e);
        check("unmapped data", d, 32'h0);
        check("unmapped error", e, 32'h1);
        wr(LRC_STAT_ADDR, 32'hff, 4'h1, e);
        check("status write error", e, 32'h1);
        $display("test fields done");

        // Pin switch needs both the direction bit and the pin enable
        for (int k = 0; k < 4; k++) begin
            wr(LRC_CTRL_ADDR, {24'h0, 1'b0, k[1], 6'h0}, 4'h1, e);
            @(posedge pclk);
            dir <= k[0];
            settle();
            check("port pin", pin, {31'h0, k[0] & k[1]});
            rd(LRC_STAT_ADDR, d, e);
            check("status pin", d[0], {31'h0, k[0] & k[1]});
        end
        $display("test pin done");

        wr(LRC_CTRL_ADDR, 32'he9, 4'h1, e);
        for (int m = 0; m < 8; m++) begin
            @(posedge pclk);
            cmode <= m[2:0];
            settle();
            check("comparator ref", cref, (m == 2) ? 32'h1 : 32'h0);
            check("ladder vs mode", {power, taps, rlow, rhigh, pin}, 32'h8_1005);
            rd(LRC_CTRL_ADDR, d, e);
            check("control vs mode", d, 32'he9);
            rd(LRC_STAT_ADDR, d, e);
            check("status vs mode", d, (m == 2) ? 32'h7 : 32'h5);
        end
        $display("test comparator done");

        wr(LRC_CTRL_ADDR, 32'h69, 4'h1, e);
        @(posedge pclk);
        sleep <= 1'b1;
        settle();
        rd(LRC_STAT_ADDR, d, e);
        check("status sleep", d[3], 32'h1);
        @(posedge pclk);
        sleep <= 1'b0;
        settle();
        rd(LRC_CTRL_ADDR, d, e);
        check("control after wake", d, 32'h69);
        check("pin after wake", pin, 32'h1);
        $display("test sleep done");

        wr(LRC_CTRL_ADDR, 32'he5, 4'h1, e);
        @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        check("outputs mid reset", {power, taps, rlow, rhigh, pin, cref}, 32'h0);
        @(posedge pclk);
        presetn <= 1'b1;
        rd(LRC_CTRL_ADDR, d, e);
        check("control after reset", d, 32'h0);
        settle();
        check("outputs after reset", {power, taps, rlow, rhigh, pin}, 32'h0);
        $display("test second reset done");
        close_out();
    end

endmodule : test_ladder_reference_control
